// File: include/sfra_consts.svh
// Constants for the serial flash read and address mode sequencer
`ifndef SFRA_CONSTS_SVH
`define SFRA_CONSTS_SVH
// Opcodes handled by the sequencer
`define SFRA_OP_READ      8'h03
`define SFRA_OP_QUICK     8'h0B
`define SFRA_OP_DUAL_OUT  8'h3B
`define SFRA_OP_DUAL_IO   8'hBB
`define SFRA_OP_QUAD_OUT  8'h6B
`define SFRA_OP_ENTER     8'hB7
`define SFRA_OP_EXIT      8'hE9
// Address phase lengths in bits, and the index of the last opcode bit
`define SFRA_ALEN_NARROW  6'h18
`define SFRA_ALEN_WIDE    6'h20
`define SFRA_OPCODE_LAST  6'h07
// Dummy clocks per select code, single and lane-output reads
`define SFRA_DC0          4'h8
`define SFRA_DC1          4'h6
`define SFRA_DC2          4'h8
`define SFRA_DC3          4'hA
// Dummy clocks for select code 00 on the dual I/O read
`define SFRA_DC0_IO       4'h4
// Register byte offsets
`define SFRA_REG_CONFIG   8'h00
`define SFRA_REG_CTRL     8'h04
`define SFRA_REG_STATUS   8'h08
`define SFRA_REG_MADDR    8'h0C
`define SFRA_REG_MDATA    8'h10
// Field positions
`define SFRA_CFG_WIDE     5
`define SFRA_CFG_DC_LO    6
`define SFRA_CTRL_BUSY    0
`define SFRA_CTRL_EXT     1
// Array geometry
`define SFRA_FLASH_AW     25
`define SFRA_MEM_AW       8
`endif

// File: include/sfra_link_if.sv
// Synchronised link events from the pin sampler to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface sfra_link_if;
  logic       cs_n;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] io;
  modport src (output cs_n, output sclk_rise, output sclk_fall, output io);
  modport dst (input cs_n, input sclk_rise, input sclk_fall, input io);
endinterface
`default_nettype wire

// File: include/sfra_pkg.sv
// Types shared by the sequencer modules
package sfra_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_TAIL, ST_IGNORE
  } sfra_state_type;
  typedef enum logic [1:0] {LANE_1, LANE_2, LANE_4} sfra_lanes_type;
endpackage

// File: rtl/sfra_link_sync.sv
// Two-stage pin synchroniser with serial clock edge detection
`timescale 1ns/1ps
`default_nettype none
module sfra_link_sync (
  // Clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Raw pins
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic [3:0] io_i,
  // Synchronised events
  sfra_link_if.src        link
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       sclk_last_reg;

  // First stage feeds only the second; all pins share the same latency
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_reg      <= 6'h01;
      sync_reg      <= 6'h01;
      sclk_last_reg <= 1'b0;
    end else if (ce_i) begin
      meta_reg      <= {io_i, sclk_i, cs_n_i};
      sync_reg      <= meta_reg;
      sclk_last_reg <= sync_reg[1];
    end
  end

  // Edges are seen from the second stage against a third
  assign link.cs_n      = sync_reg[0];
  assign link.sclk_rise = sync_reg[1] & ~sclk_last_reg;
  assign link.sclk_fall = ~sync_reg[1] & sclk_last_reg;
  assign link.io        = sync_reg[5:2];
endmodule
`default_nettype wire

// File: rtl/sfra_mem.sv
// Byte array with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "sfra_consts.svh"
module sfra_mem (
  // Clock and control
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Write port
  input  wire logic                    we_i,
  input  wire logic [`SFRA_MEM_AW-1:0] waddr_i,
  input  wire logic [7:0]              wdata_i,
  // Read port
  input  wire logic [`SFRA_MEM_AW-1:0] raddr_i,
  output logic      [7:0]              rdata_o
);
  logic [7:0] mem_reg [0:(1<<`SFRA_MEM_AW)-1];

  // Array is left uninitialised; software loads it before reading
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Read data always comes from a register, one cycle after the address
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule
`default_nettype wire

// File: rtl/sfra_top.sv
// Serial flash read sequencer with 24/32-bit address mode and register slave
// Summary of operation
// - After reset addresses are 24 bits until the enter command.
// - Enter command sets the wide flag at bit 5; addresses become 32 bits.
// - Wide mode ends only by exit command or reset.
// - Exit command clears the wide flag; addresses return to 24 bits.
// - In wide mode all commands work; only address length changes.
// - Top-region quad read, table, signature and ID reads never use 32 bits.
// - Inputs sampled on serial clock rise, outputs changed on fall.
// - Read address increments per byte and wraps to zero at the top.
// - Plain read: single-lane address, no dummies, stops when select rises.
// - Quick read waits the dummy clocks, default 8, then single-lane data.
// - Reads are refused while a program, erase or write cycle runs.
// - Dual output read: lane 0 address and dummies, data on lanes 1 and 0.
// - Dual I/O read: two-lane address, default 4 dummies, two-lane data.
// - Quad output read: single-lane address, default 8 dummies, four-lane data.
// - Two-bit select gives 8,6,8,10 dummies, or 4,6,8,10 for dual I/O.
// - Wide flag is a volatile bit: 0 three-byte, 1 four-byte, 0 at reset.
`timescale 1ns/1ps
`default_nettype none
`include "sfra_consts.svh"
module sfra_top (
  // Clock, reset, enable
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Flash pins
  input  wire logic        flash_cs_n_i,
  input  wire logic        flash_sclk_i,
  input  wire logic [3:0]  io_lane_i,
  output logic      [3:0]  io_lane_o,
  output logic      [3:0]  io_lane_oe_o,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  sfra_link_if link ();

  sfra_pkg::sfra_state_type       st_reg;
  sfra_pkg::sfra_lanes_type       lanes_reg;
  logic [7:0]                     op_reg;
  logic [7:0]                     last_op_reg;
  logic [5:0]                     cnt_reg;
  logic [3:0]                     dummy_reg;
  logic                           dual_in_reg;
  logic [31:0]                    addr_sh_reg;
  logic [`SFRA_FLASH_AW-1:0]      cur_addr_reg;
  logic [7:0]                     out_sh_reg;
  logic [2:0]                     bitpos_reg;
  logic                           cs_last_reg;
  logic                           wide_reg;
  logic [1:0]                     dc_reg;
  logic                           busy_reg;
  logic                           ext_reg;
  logic [`SFRA_MEM_AW-1:0]        maddr_reg;
  logic                           ack_reg;
  logic [7:0]                     mem_q;
  logic [7:0]                     op_full;
  logic [31:0]                    addr_sh_next;
  logic [5:0]                     cnt_step;
  logic [5:0]                     alen;
  logic [`SFRA_FLASH_AW-1:0]      addr_eff;
  logic [7:0]                     out_byte;
  logic                           op_done;
  logic                           addr_done;
  logic                           mode_evt;
  logic                           load_byte;
  logic                           fall_data;
  logic                           bus_req;
  logic                           bus_take;
  logic                           mem_we;

  // Opcodes that start an array read in this block
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `SFRA_OP_READ) || (op == `SFRA_OP_QUICK) ||
              (op == `SFRA_OP_DUAL_OUT) || (op == `SFRA_OP_DUAL_IO) ||
              (op == `SFRA_OP_QUAD_OUT);
  endfunction

  // Output lane count per read opcode
  function automatic sfra_pkg::sfra_lanes_type lanes_of(input logic [7:0] op);
    if (op == `SFRA_OP_QUAD_OUT) begin
      lanes_of = sfra_pkg::LANE_4;
    end else if (op == `SFRA_OP_DUAL_OUT || op == `SFRA_OP_DUAL_IO) begin
      lanes_of = sfra_pkg::LANE_2;
    end else begin
      lanes_of = sfra_pkg::LANE_1;
    end
  endfunction

  // Dummy clocks from opcode and select code
  function automatic logic [3:0] dummy_of(input logic [7:0] op, input logic [1:0] dc);
    logic [3:0] d;
    d = 4'h0;
    case (dc)
      2'h0: d = (op == `SFRA_OP_DUAL_IO) ? `SFRA_DC0_IO : `SFRA_DC0;
      2'h1: d = `SFRA_DC1;
      2'h2: d = `SFRA_DC2;
      default: d = `SFRA_DC3;
    endcase
    dummy_of = (op == `SFRA_OP_READ) ? 4'h0 : d;
  endfunction

  // Lanes driven while data goes out; single lane data leaves on lane 1
  function automatic logic [3:0] lane_mask(input sfra_pkg::sfra_lanes_type l);
    case (l)
      sfra_pkg::LANE_4: lane_mask = 4'hF;
      sfra_pkg::LANE_2: lane_mask = 4'h3;
      default:          lane_mask = 4'h2;
    endcase
  endfunction

  // Bits sent per serial clock
  function automatic logic [2:0] lane_step(input sfra_pkg::sfra_lanes_type l);
    case (l)
      sfra_pkg::LANE_4: lane_step = 3'h4;
      sfra_pkg::LANE_2: lane_step = 3'h2;
      default:          lane_step = 3'h1;
    endcase
  endfunction

  // Top bits of the byte placed on the lanes, MSB on the highest lane
  function automatic logic [3:0] out_nibble(input logic [7:0] b,
                                            input sfra_pkg::sfra_lanes_type l);
    case (l)
      sfra_pkg::LANE_4: out_nibble = b[7:4];
      sfra_pkg::LANE_2: out_nibble = {2'h0, b[7:6]};
      default:          out_nibble = {2'h0, b[7], 1'h0};
    endcase
  endfunction

  sfra_link_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .cs_n_i    (flash_cs_n_i),
    .sclk_i    (flash_sclk_i),
    .io_i      (io_lane_i),
    .link      (link)
  );

  sfra_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .we_i      (mem_we),
    .waddr_i   (maddr_reg),
    .wdata_i   (avs_writedata_i[7:0]),
    .raddr_i   (cur_addr_reg[`SFRA_MEM_AW-1:0]),
    .rdata_o   (mem_q)
  );

  // Shift-in paths, MSB first; dual I/O takes lane 1 as the upper bit
  assign op_full      = {op_reg[6:0], link.io[0]};
  assign addr_sh_next = dual_in_reg ? {addr_sh_reg[29:0], link.io[1:0]}
                                    : {addr_sh_reg[30:0], link.io[0]};
  assign cnt_step     = dual_in_reg ? 6'h02 : 6'h01;
  assign alen         = wide_reg ? `SFRA_ALEN_WIDE : `SFRA_ALEN_NARROW;
  // Narrow mode puts the extended address bit above the 24 received bits
  assign addr_eff     = wide_reg ? addr_sh_next[`SFRA_FLASH_AW-1:0]
                                 : {ext_reg, addr_sh_next[23:0]};
  assign op_done      = link.sclk_rise && !link.cs_n && st_reg == sfra_pkg::ST_OPCODE &&
                        cnt_reg == `SFRA_OPCODE_LAST;
  assign addr_done    = link.sclk_rise && !link.cs_n && st_reg == sfra_pkg::ST_ADDR &&
                        (cnt_reg + cnt_step) == alen;
  // A mode command counts only if select rises right after its eighth bit
  assign mode_evt     = link.cs_n && !cs_last_reg && st_reg == sfra_pkg::ST_TAIL;
  assign fall_data    = link.sclk_fall && !link.cs_n && st_reg == sfra_pkg::ST_DATA;
  assign load_byte    = fall_data && bitpos_reg == 3'h0;
  assign out_byte     = load_byte ? mem_q : out_sh_reg;

  // Frame sequencer: opcode, address, dummies, data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg      <= sfra_pkg::ST_OPCODE;
      lanes_reg   <= sfra_pkg::LANE_1;
      op_reg      <= 8'h00;
      last_op_reg <= 8'h00;
      cnt_reg     <= 6'h00;
      dummy_reg   <= 4'h0;
      dual_in_reg <= 1'b0;
      addr_sh_reg <= 32'h0;
      cs_last_reg <= 1'b1;
    end else if (ce_i) begin
      cs_last_reg <= link.cs_n;
      if (link.cs_n) begin
        st_reg      <= sfra_pkg::ST_OPCODE;
        cnt_reg     <= 6'h00;
        dual_in_reg <= 1'b0;
      end else if (link.sclk_rise) begin
        case (st_reg)
          sfra_pkg::ST_OPCODE: begin
            op_reg  <= op_full;
            cnt_reg <= cnt_reg + 6'h01;
            if (op_done) begin
              last_op_reg <= op_full;
              cnt_reg     <= 6'h00;
              lanes_reg   <= lanes_of(op_full);
              dummy_reg   <= dummy_of(op_full, dc_reg);
              dual_in_reg <= (op_full == `SFRA_OP_DUAL_IO);
              if (!is_read(op_full)) begin
                // Other opcodes, including the 24-bit-only reads, are not decoded here
                st_reg <= sfra_pkg::ST_TAIL;
              end else if (busy_reg) begin
                st_reg <= sfra_pkg::ST_IGNORE;
              end else begin
                st_reg <= sfra_pkg::ST_ADDR;
              end
            end
          end
          sfra_pkg::ST_ADDR: begin
            addr_sh_reg <= addr_sh_next;
            cnt_reg     <= cnt_reg + cnt_step;
            if (addr_done) begin
              cnt_reg <= 6'h00;
              st_reg  <= (dummy_reg == 4'h0) ? sfra_pkg::ST_DATA
                                             : sfra_pkg::ST_DUMMY;
            end
          end
          sfra_pkg::ST_DUMMY: begin
            cnt_reg <= cnt_reg + 6'h01;
            if ((cnt_reg + 6'h01) == {2'h0, dummy_reg}) begin
              cnt_reg <= 6'h00;
              st_reg  <= sfra_pkg::ST_DATA;
            end
          end
          sfra_pkg::ST_TAIL: begin
            st_reg <= sfra_pkg::ST_IGNORE;
          end
          default: st_reg <= st_reg;
        endcase
      end
    end
  end

  // Address mode flag; leaves wide mode only by command or reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wide_reg <= 1'b0;
    end else if (ce_i && mode_evt) begin
      if (op_reg == `SFRA_OP_ENTER) begin
        wide_reg <= 1'b1;
      end else if (op_reg == `SFRA_OP_EXIT) begin
        wide_reg <= 1'b0;
      end
    end
  end

  // Data path: address counter, output shifter and lane drive on falls
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_addr_reg <= '0;
      out_sh_reg   <= 8'h00;
      bitpos_reg   <= 3'h0;
      io_lane_o    <= 4'h0;
      io_lane_oe_o <= 4'h0;
    end else if (ce_i) begin
      if (addr_done) begin
        cur_addr_reg <= addr_eff;
        bitpos_reg   <= 3'h0;
      end
      if (link.cs_n || st_reg != sfra_pkg::ST_DATA) begin
        io_lane_oe_o <= 4'h0;
      end else if (fall_data) begin
        io_lane_o    <= out_nibble(out_byte, lanes_reg);
        io_lane_oe_o <= lane_mask(lanes_reg);
        out_sh_reg   <= out_byte << lane_step(lanes_reg);
        bitpos_reg   <= bitpos_reg + lane_step(lanes_reg);
        if (load_byte) begin
          // 25-bit counter, wider than the 8-bit array index, rolls over to zero only at the top of its own range
          cur_addr_reg <= cur_addr_reg + 1'b1;
        end
      end
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign bus_take          = bus_req & ack_reg;
  assign mem_we            = ce_i && bus_take && avs_write_i && avs_byteenable_i[0] &&
                             avs_address_i == `SFRA_REG_MDATA;

  // Wait flag and registered read data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else if (ce_i) begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req && !ack_reg) begin
        if (avs_address_i == `SFRA_REG_CONFIG) begin
          avs_readdata_o <= {24'h0, dc_reg, wide_reg, 5'h00};
        end else if (avs_address_i == `SFRA_REG_CTRL) begin
          avs_readdata_o <= {30'h0, ext_reg, busy_reg};
        end else if (avs_address_i == `SFRA_REG_STATUS) begin
          avs_readdata_o <= {21'h0, 3'(st_reg), last_op_reg};
        end else if (avs_address_i == `SFRA_REG_MADDR) begin
          avs_readdata_o <= {24'h0, maddr_reg};
        end else begin
          avs_readdata_o <= 32'h0;
        end
      end
    end
  end

  // Software-written control; the wide flag is read-only here
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dc_reg    <= 2'h0;
      busy_reg  <= 1'b0;
      ext_reg   <= 1'b0;
      maddr_reg <= '0;
    end else if (ce_i && bus_take && avs_write_i && avs_byteenable_i[0]) begin
      if (avs_address_i == `SFRA_REG_CONFIG) begin
        dc_reg <= avs_writedata_i[`SFRA_CFG_DC_LO+1:`SFRA_CFG_DC_LO];
      end else if (avs_address_i == `SFRA_REG_CTRL) begin
        busy_reg <= avs_writedata_i[`SFRA_CTRL_BUSY];
        ext_reg  <= avs_writedata_i[`SFRA_CTRL_EXT];
      end else if (avs_address_i == `SFRA_REG_MADDR) begin
        maddr_reg <= avs_writedata_i[`SFRA_MEM_AW-1:0];
      end else if (avs_address_i == `SFRA_REG_MDATA) begin
        maddr_reg <= maddr_reg + 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_wide_after_reset: assert property ($fell(rst_i) |-> !wide_reg)
    else $error("wide flag set after reset");
  a_enter_sets: assert property (ce_i && mode_evt && op_reg == `SFRA_OP_ENTER |=> wide_reg)
    else $error("enter command did not set wide flag");
  a_exit_clears: assert property (ce_i && mode_evt && op_reg == `SFRA_OP_EXIT |=> !wide_reg)
    else $error("exit command did not clear wide flag");
  // A reset in mid-run may also move the flag; that edge is not a violation
  a_wide_holds: assert property ($changed(wide_reg)
                                 |-> $past(rst_i || (mode_evt && ce_i)))
    else $error("wide flag changed without a mode command");
  a_busy_reject: assert property (ce_i && op_done && busy_reg && is_read(op_full)
                                  |=> st_reg == sfra_pkg::ST_IGNORE)
    else $error("read accepted while busy");
  a_dummy_len: assert property (st_reg == sfra_pkg::ST_DATA &&
                                $past(st_reg) == sfra_pkg::ST_DUMMY
                                |-> $past(cnt_reg) + 6'h01 == {2'h0, dummy_reg})
    else $error("wrong dummy clock count");
  a_oe_cs_off: assert property (ce_i && link.cs_n |=> io_lane_oe_o == 4'h0)
    else $error("lanes driven with select high");
  a_oe_lanes: assert property (io_lane_oe_o != 4'h0 |-> io_lane_oe_o == lane_mask(lanes_reg))
    else $error("wrong lanes driven");
  a_drive_fall: assert property ($changed(io_lane_o)
                                 |-> $past(rst_i || (fall_data && ce_i)))
    else $error("output changed off a falling edge");
  a_addr_incr: assert property (ce_i && load_byte
                                |=> cur_addr_reg == $past(cur_addr_reg) + 1'b1)
    else $error("address did not advance");
endmodule
`default_nettype wire

// File: testbench/sfra_host.sv
// Host controller model: drives select, serial clock and lanes, collects read bytes
`timescale 1ns/1ps
`default_nettype none
module sfra_host (
  // Pins towards the device
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic      [3:0] io_o,
  // Lane levels as seen on the wires
  input  wire logic [3:0] io_i
);
  logic [7:0] rd [8];
  // Idle: deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o   = 4'h0;
  end
  // Groups of w bits, top group first; lanes change only while the clock is low
  // Pins move by non-blocking assignment so a coinciding system edge sees old levels
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      io_o <= 4'(v >> (32 - w));
      v = v << w;
      #62.5 sclk_o <= 1'b1;
      #62.5 sclk_o <= 1'b0;
    end
  endtask
  // One frame; released lanes toggle so a stale level never passes for data
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab,
                       input int aw, input int nd, input int dw, input int nb);
    logic [7:0] b;
    cs_n_o <= 1'b0;
    send({op, 24'h0}, 8, 1);
    if (ab > 0) send(a << (32 - ab), ab / aw, aw);
    send(32'h0, nd, aw);
    for (int j = 0; j < nb; j++) begin
      for (int k = 0; k < 8 / dw; k++) begin
        io_o <= ~io_o;
        #62.5 sclk_o <= 1'b1;
        b = (dw == 1) ? {b[6:0], io_i[1]} : 8'((b << dw) | (io_i & 4'((1 << dw) - 1)));
        #62.5 sclk_o <= 1'b0;
      end
      rd[j] = b;
    end
    #62.5 cs_n_o <= 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the serial flash read sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfra_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, oe_seen, cs_n, sclk;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o;
  logic [3:0]  io_lane_o, io_lane_oe_o, host_io, lanes;
  logic [7:0]  img [256];
  int          mismatches, n_compared;
  // Each lane shows the device where it drives, the host elsewhere
  assign lanes = (io_lane_oe_o & io_lane_o) | (~io_lane_oe_o & host_io);
  sfra_host i_sfra_host (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(host_io), .io_i(lanes));
  sfra_top i_sfra_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .flash_cs_n_i(cs_n), .flash_sclk_i(sclk), .io_lane_i(lanes), .io_lane_o(io_lane_o),
    .io_lane_oe_o(io_lane_oe_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Catches any drive from the device during a refused frame
  always @(posedge sys_clk_i) if (|io_lane_oe_o) oe_seen <= 1'b1;
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Bus cycle held until waitrequest is sampled low at a rising edge; read data taken there
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    for (int n = 0; n < 20; n++) begin
      @(posedge sys_clk_i);
      if (avs_waitrequest_o === 1'b0) begin
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        return;
      end
    end
    mismatches++;
    complete_run();
  endtask
  // Frame through the host, then compare bytes with the image
  task automatic rd_chk(input logic [7:0] op, input logic [31:0] a, input int ab, input int aw,
                        input int nd, input int dw, input int nb);
    i_sfra_host.frame(op, a, ab, aw, nd, dw, nb);
    for (int j = 0; j < nb; j++) `CHK(i_sfra_host.rd[j], img[8'(a + j)])
  endtask
  task automatic t_reset();
    av(0, `SFRA_REG_CONFIG, 0);
    `CHK(q, 32'h0)
    av(0, 8'h40, 0);
    `CHK(q, 32'h0)
  endtask
  // Narrow read across the top of the low range; select rise stops the output
  task automatic t_plain();
    rd_chk(`SFRA_OP_READ, 32'hFFFFFE, 24, 1, 0, 1, 4);
    `CHK(io_lane_oe_o, 4'h0)
  endtask
  task automatic t_wide();
    i_sfra_host.frame(`SFRA_OP_ENTER, 0, 0, 1, 0, 1, 0);
    av(0, `SFRA_REG_CONFIG, 0);
    `CHK(q[5], 1'b1)
    rd_chk(`SFRA_OP_READ, 32'h01FFFFFF, 32, 1, 0, 1, 3);
    rd_chk(`SFRA_OP_DUAL_IO, 32'h00000010, 32, 2, 4, 2, 2);
    i_sfra_host.frame(`SFRA_OP_EXIT, 0, 0, 1, 0, 1, 0);
    av(0, `SFRA_REG_CONFIG, 0);
    `CHK(q[5], 1'b0)
    rd_chk(`SFRA_OP_READ, 32'h000020, 24, 1, 0, 1, 2);
  endtask
  // Every select code on every read with dummies; dual I/O has its own default
  task automatic t_dummy();
    logic [7:0] ops [4] = '{`SFRA_OP_QUICK, `SFRA_OP_DUAL_OUT, `SFRA_OP_QUAD_OUT, `SFRA_OP_DUAL_IO};
    int         tab [4] = '{8, 6, 8, 10};
    for (int c = 0; c < 4; c++) begin
      av(1, `SFRA_REG_CONFIG, 32'(c << 6));
      for (int k = 0; k < 4; k++)
        rd_chk(ops[k], 32'(16 * c + 3 * k), 24, k == 3 ? 2 : 1, (k == 3 && c == 0) ? 4 : tab[c],
               k == 2 ? 4 : (k == 0 ? 1 : 2), 3);
    end
    av(1, `SFRA_REG_CONFIG, 0);
  endtask
  task automatic t_busy();
    av(1, `SFRA_REG_CTRL, 32'h1);
    @(negedge sys_clk_i) oe_seen = 1'b0;
    i_sfra_host.frame(`SFRA_OP_QUICK, 0, 24, 1, 8, 1, 2);
    `CHK(oe_seen, 1'b0)
    av(1, `SFRA_REG_CTRL, 32'h0);
    rd_chk(`SFRA_OP_QUICK, 0, 24, 1, 8, 1, 2);
  endtask
  // Reset in mid-run leaves wide mode
  task automatic t_rst();
    i_sfra_host.frame(`SFRA_OP_ENTER, 0, 0, 1, 0, 1, 0);
    av(0, `SFRA_REG_CONFIG, 0);
    `CHK(q[5], 1'b1)
    @(posedge sys_clk_i) rst_i <= 1'b1;
    @(posedge sys_clk_i) rst_i <= 1'b0;
    av(0, `SFRA_REG_CONFIG, 0);
    `CHK(q[5], 1'b0)
  endtask
  initial begin
    {rst_i, avs_read_i, avs_write_i, oe_seen} = 4'h8;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    av(1, `SFRA_REG_MADDR, 0);
    for (int i = 0; i < 256; i++) begin
      img[i] = 8'h5A ^ 8'(i * 37);
      av(1, `SFRA_REG_MDATA, {24'h0, img[i]});
    end
    t_reset();
    t_plain();
    t_wide();
    t_dummy();
    t_busy();
    t_rst();
    complete_run();
  end
  // Hang guard
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
